// ==== include/fps_pkg.sv ====
// package: constants, types and parameter table of the front-panel setting controller
// assumes a 10 MHz system clock and a synchronous active-high reset
package fps_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS = 20;
  localparam int HOLD_LONG_MS = 1000;
  localparam int HOLD_ENTRY_MS = 3000;
  localparam int LAMP_TEST_MS = 3000;
  localparam int BLINK_HALF_MS = 500;
  localparam int MS_PER_S = 1000;
  localparam int NKEYS = 5;
  localparam int NPARAM = 8;
  localparam int NDIG = 5;
  localparam int MSD = NDIG - 1;
  localparam int DC_W = 16;
  localparam int ALM_W = 5;
  localparam logic [3:0] DIG_MINUS = 4'hA;
  localparam logic [3:0] DIG_NINE = 4'h9;
  localparam logic [2:0] INIT_FIRST = 3'h0;
  localparam logic [2:0] INIT_LAST = 3'h2;
  localparam logic [2:0] ALARM_FIRST = 3'h3;
  localparam logic [2:0] ALARM_LAST = 3'h3;
  localparam logic [2:0] ADV_FIRST = 3'h4;
  localparam logic [2:0] ADV_LAST = 3'h7;
  localparam logic [2:0] PARAM_ALARM_SP = 3'h3;
  localparam logic [2:0] PARAM_AUTO_RET = 3'h7;
  localparam int ADDR_MIN = 1;
  localparam int ADDR_MAX = 99;
  localparam int TMR_MIN = 1;
  localparam int TMR_MAX = 999;
  localparam logic [19:0] AUTO_RET_DEF = 20'h00015;
  localparam logic [19:0] ADDR_DEF = 20'h00001;
  localparam logic [19:0] TMR_DEF = 20'h00010;

  typedef enum logic [2:0] {MODE_LAMP, MODE_MEAS, MODE_INIT, MODE_ALARM, MODE_ADV} fps_mode_e;
  typedef enum logic [1:0] {FULL_EDIT_LEVEL, PARTIAL_EDIT_LEVEL, NO_EDIT_LEVEL} fps_lock_e;

  typedef struct packed {
    logic extreme;
    logic init_up;
    logic alarm_down;
    logic up;
    logic shift;
  } fps_keys_s;

  typedef struct packed {
    logic sel;
    logic [3:0] sel_cnt;
    logic lock_part;
    logic has_range;
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    logic [55:0] text;
  } fps_attr_s;

  localparam fps_attr_s PARAM_ATTR [NPARAM] = '{
    '{1'b1, 4'hE, 1'b0, 1'b0, 18'sh00000, 18'sh00000, "TCTYPE "},
    '{1'b1, 4'h2, 1'b0, 1'b0, 18'sh00000, 18'sh00000, "UNIT   "},
    '{1'b1, 4'h4, 1'b0, 1'b0, 18'sh00000, 18'sh00000, "D-POINT"},
    '{1'b0, 4'h0, 1'b0, 1'b0, 18'sh00000, 18'sh00000, "ALM-SP "},
    '{1'b0, 4'h0, 1'b1, 1'b1, 18'(ADDR_MIN), 18'(ADDR_MAX), "ADDRESS"},
    '{1'b0, 4'h0, 1'b1, 1'b1, 18'(TMR_MIN), 18'(TMR_MAX), "T1.5   "},
    '{1'b0, 4'h0, 1'b1, 1'b1, 18'(TMR_MIN), 18'(TMR_MAX), "T3.5   "},
    '{1'b0, 4'h0, 1'b0, 1'b0, 18'sh00000, 18'sh00000, "AUTORET"}
  };

  localparam logic [19:0] PARAM_RESET [NPARAM] = '{
    20'h00000, 20'h00000, 20'h00000, 20'h00000, ADDR_DEF, TMR_DEF, TMR_DEF, AUTO_RET_DEF
  };
endpackage : fps_pkg

// ==== verilog/fps_keypad.sv ====
// file: debounce and press-duration detection of the five front buttons
// assumes raw button levels synchronous to clk, active high, and a 1 ms tick pulse
`timescale 1ns/10ps
module fps_keypad import fps_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ms_tick,
  input wire fps_keys_s keys_raw,
  output fps_keys_s level,
  output fps_keys_s press,
  output fps_keys_s short_rel,
  output fps_keys_s hold_long,
  output fps_keys_s hold_entry
);
  logic [NKEYS-1:0] raw_v;
  logic [NKEYS-1:0] lvl_v;
  logic [NKEYS-1:0] press_v;
  logic [NKEYS-1:0] short_v;
  logic [NKEYS-1:0] long_v;
  logic [NKEYS-1:0] entry_v;

  assign raw_v = keys_raw;

  for (genvar k = 0; k < NKEYS; k++) begin : g_key
    logic lvl_reg, lvl_next;
    logic prev_reg;
    logic [4:0] db_reg, db_next;
    logic [11:0] hold_reg, hold_next;
    // stable-for-debounce-time filter and held-time counter
    always_comb begin
      lvl_next = lvl_reg;
      db_next = db_reg;
      hold_next = hold_reg;
      if (raw_v[k] == lvl_reg) begin
        db_next = 5'h00;
      end else if (ms_tick) begin
        if (db_reg == 5'(DEBOUNCE_MS - 1)) begin
          lvl_next = raw_v[k];
          db_next = 5'h00;
        end else begin
          db_next = db_reg + 5'h01;
        end
      end
      if (!lvl_reg) begin
        hold_next = 12'h000;
      end else if (ms_tick && hold_reg != 12'(HOLD_ENTRY_MS)) begin
        hold_next = hold_reg + 12'h001;
      end
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        lvl_reg <= 1'b0;
        prev_reg <= 1'b0;
        db_reg <= 5'h00;
        hold_reg <= 12'h000;
      end else begin
        lvl_reg <= lvl_next;
        prev_reg <= lvl_reg;
        db_reg <= db_next;
        hold_reg <= hold_next;
      end
    end
    assign lvl_v[k] = lvl_reg; // RULE19
    assign press_v[k] = lvl_reg & ~prev_reg;
    assign short_v[k] = prev_reg & ~lvl_reg & (hold_reg < 12'(HOLD_LONG_MS)); // RULE19
    assign long_v[k] = ms_tick & lvl_reg & (hold_reg == 12'(HOLD_LONG_MS - 1)); // RULE19
    assign entry_v[k] = ms_tick & lvl_reg & (hold_reg == 12'(HOLD_ENTRY_MS - 1)); // RULE19
  end

  assign level = lvl_v;
  assign press = press_v;
  assign short_rel = short_v;
  assign hold_long = long_v;
  assign hold_entry = entry_v;
endmodule : fps_keypad

// ==== verilog/fps_front_panel.sv ====
// file: front-panel parameter-setting controller of a panel meter
// assumes buttons synchronous to clk, measured dc/alarm data from the measuring core
//
// Contract
// [RULE1] init_up held 3 s enters initial setting
// [RULE2] shift starts numeric edit at leftmost digit
// [RULE3] each shift moves edit digit right
// [RULE4] up increments digit, minus after nine where allowed
// [RULE5] selection: shift blinks value, up advances it
// [RULE6] short down/init commits, moves next/previous
// [RULE7] down/init held 1 s commits, back measuring
// [RULE8] standby idle timeout commits, stops blinking
// [RULE9] idle timeout elsewhere returns to measuring
// [RULE10] extreme held 1 s discards pending edit
// [RULE11] three lockout levels in alarm/advanced modes
// [RULE12] invalid lamp blinks while value out of range
// [RULE13] address and timers beyond range are invalid
// [RULE14] minus only legal in leftmost digit
// [RULE15] dc and alarm outputs held in setting
// [RULE16] no mode change while parameter error shown
// [RULE17] sub display shows seven-character parameter id
// [RULE18] all lamps three seconds after power-up
// [RULE19] debounced buttons timed on millisecond tick
`timescale 1ns/10ps
module fps_front_panel import fps_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fps_keys_s keys_raw,
  input wire fps_lock_e lock_level,
  input wire logic p_err,
  input wire logic [DC_W-1:0] meas_dc,
  input wire logic [ALM_W-1:0] meas_alarm,
  output fps_mode_e mode,
  output logic measure_run,
  output logic bcd_valid,
  output logic lamp_test,
  output logic [DC_W-1:0] dc_out,
  output logic [ALM_W-1:0] alarm_out,
  output logic [2:0] param_idx,
  output logic [19:0] main_digits,
  output logic [NDIG-1:0] blink_mask,
  output logic invalid_lamp,
  output logic [55:0] secondary_text_display,
  output logic commit_pulse
);
  localparam int TW = $clog2(TICK_CYC);

  fps_keys_s kp_level, kp_press, kp_short, kp_long, kp_entry;
  logic [TW-1:0] tick_reg, tick_next;
  logic ms_tick_reg, ms_tick_next;
  logic [9:0] msec_reg, msec_next;
  logic [8:0] blink_ms_reg, blink_ms_next;
  logic blink_reg, blink_next;
  logic sec_tick;
  fps_mode_e mode_reg, mode_next;
  logic standby_reg, standby_next;
  logic [2:0] pidx_reg, pidx_next;
  logic [2:0] pos_reg, pos_next;
  logic [19:0] edit_reg, edit_next;
  logic [19:0] store_reg [NPARAM];
  logic [19:0] store_next [NPARAM];
  logic [11:0] lamp_reg, lamp_next;
  logic [16:0] idle_reg, idle_next;
  logic commit_reg, commit_next;
  logic [DC_W-1:0] dc_reg, dc_next;
  logic [ALM_W-1:0] alm_reg, alm_next;
  fps_attr_s attr;
  logic [2:0] first_p, last_p;
  logic [16:0] mag, ret_s;
  logic signed [17:0] sval;
  logic minus_low, range_bad, edit_bad;
  logic any_key, in_set, timeout, editable, minus_ok;
  logic long_exit, short_mv, busy_ev, do_commit;
  logic [3:0] dig, nd;
  logic [19:0] store_cur;

  function automatic logic [16:0] digits_mag(input logic [19:0] d);
    logic [16:0] m;
    m = 17'h00000;
    for (int i = MSD; i >= 0; i--) begin
      m = 17'(m * 17'h0000A);
      if (d[i*4 +: 4] <= DIG_NINE) begin
        m = m + {13'h0000, d[i*4 +: 4]};
      end
    end
    return m;
  endfunction : digits_mag

  fps_keypad u_keypad (
    .clk(clk),
    .sys_rst(sys_rst),
    .ms_tick(ms_tick_reg),
    .keys_raw(keys_raw),
    .level(kp_level),
    .press(kp_press),
    .short_rel(kp_short),
    .hold_long(kp_long),
    .hold_entry(kp_entry)
  );

  // millisecond, second and blink timebase
  assign sec_tick = ms_tick_reg && msec_reg == 10'(MS_PER_S - 1);
  always_comb begin
    tick_next = tick_reg + TW'(1);
    ms_tick_next = 1'b0;
    msec_next = msec_reg;
    blink_ms_next = blink_ms_reg;
    blink_next = blink_reg;
    if (tick_reg == TW'(TICK_CYC - 1)) begin
      tick_next = '0;
      ms_tick_next = 1'b1;
    end
    if (ms_tick_reg) begin
      msec_next = sec_tick ? 10'h000 : msec_reg + 10'h001;
      if (blink_ms_reg == 9'(BLINK_HALF_MS - 1)) begin
        blink_ms_next = 9'h000;
        blink_next = ~blink_reg;
      end else begin
        blink_ms_next = blink_ms_reg + 9'h001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_reg <= '0;
      ms_tick_reg <= 1'b0;
      msec_reg <= 10'h000;
      blink_ms_reg <= 9'h000;
      blink_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      ms_tick_reg <= ms_tick_next;
      msec_reg <= msec_next;
      blink_ms_reg <= blink_ms_next;
      blink_reg <= blink_next;
    end
  end

  // parameter attributes and validity of the pending value
  assign attr = PARAM_ATTR[pidx_reg];
  assign store_cur = store_reg[pidx_reg];
  always_comb begin
    case (mode_reg)
      MODE_ALARM: begin
        first_p = ALARM_FIRST;
        last_p = ALARM_LAST;
      end
      MODE_ADV: begin
        first_p = ADV_FIRST;
        last_p = ADV_LAST;
      end
      default: begin
        first_p = INIT_FIRST;
        last_p = INIT_LAST;
      end
    endcase
  end
  always_comb begin
    minus_low = 1'b0;
    for (int i = 0; i < MSD; i++) begin
      if (edit_reg[i*4 +: 4] == DIG_MINUS) minus_low = 1'b1; // RULE14
    end
    mag = digits_mag(edit_reg);
    sval = (edit_reg[MSD*4 +: 4] == DIG_MINUS) ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    range_bad = attr.has_range && (sval < attr.lo || sval > attr.hi); // RULE13
    edit_bad = !attr.sel && (minus_low || range_bad);
  end

  assign in_set = mode_reg == MODE_INIT || mode_reg == MODE_ALARM || mode_reg == MODE_ADV;
  assign any_key = |kp_level;
  assign ret_s = digits_mag(store_reg[PARAM_AUTO_RET]);
  assign timeout = in_set && sec_tick && !any_key && ret_s != 17'h00000 && idle_reg == ret_s - 17'h00001;
  assign editable = !((mode_reg == MODE_ALARM || mode_reg == MODE_ADV) &&
    (lock_level == NO_EDIT_LEVEL || (lock_level == PARTIAL_EDIT_LEVEL && attr.lock_part))); // RULE11
  assign minus_ok = (mode_reg == MODE_INIT && pos_reg == 3'(MSD)) || pidx_reg == PARAM_ALARM_SP;
  assign long_exit = kp_long.alarm_down | kp_long.init_up;
  assign short_mv = kp_short.alarm_down | kp_short.init_up;
  assign busy_ev = long_exit | timeout | kp_long.extreme | short_mv;
  assign dig = edit_reg[{pos_reg, 2'b00} +: 4];

  // mode and edit sequencing
  always_comb begin
    mode_next = mode_reg;
    standby_next = standby_reg;
    pidx_next = pidx_reg;
    pos_next = pos_reg;
    edit_next = edit_reg;
    lamp_next = lamp_reg;
    commit_next = 1'b0;
    store_next = store_reg;
    do_commit = 1'b0;
    nd = 4'h0;
    if (any_key || !in_set || timeout) idle_next = 17'h00000;
    else if (sec_tick) idle_next = idle_reg + 17'h00001;
    else idle_next = idle_reg;
    case (mode_reg)
      MODE_LAMP: begin
        if (ms_tick_reg) begin
          if (lamp_reg == 12'(LAMP_TEST_MS - 1)) mode_next = MODE_MEAS; // RULE18
          else lamp_next = lamp_reg + 12'h001;
        end
      end
      MODE_MEAS: begin
        standby_next = 1'b0;
        pos_next = 3'(MSD);
        if (!p_err) begin // RULE16
          if (kp_entry.init_up) begin
            mode_next = MODE_INIT; // RULE1
            pidx_next = INIT_FIRST;
          end else if (kp_entry.alarm_down) begin
            mode_next = MODE_ALARM;
            pidx_next = ALARM_FIRST;
          end else if (kp_entry.extreme) begin
            mode_next = MODE_ADV;
            pidx_next = ADV_FIRST;
          end
        end
      end
      default: begin
        if (long_exit) begin
          do_commit = standby_reg && !edit_bad; // RULE7
          standby_next = 1'b0;
          if (!p_err) mode_next = MODE_MEAS; // RULE7 RULE16
        end else if (timeout) begin
          if (standby_reg) begin
            do_commit = !edit_bad; // RULE8
            standby_next = 1'b0;
          end else if (!p_err) begin
            mode_next = MODE_MEAS; // RULE9
          end
        end else if (standby_reg && kp_long.extreme) begin
          standby_next = 1'b0; // RULE10
        end else if (short_mv) begin
          if (!standby_reg || !edit_bad) begin // RULE12
            do_commit = standby_reg; // RULE6
            standby_next = 1'b0;
            if (kp_short.alarm_down) pidx_next = (pidx_reg == last_p) ? first_p : pidx_reg + 3'h1; // RULE6
            else pidx_next = (pidx_reg == first_p) ? last_p : pidx_reg - 3'h1; // RULE6
          end
        end else if (kp_press.shift) begin
          if (!standby_reg) begin
            if (editable) begin // RULE11
              standby_next = 1'b1; // RULE2 RULE5
              edit_next = store_cur;
              pos_next = 3'(MSD); // RULE2
            end
          end else if (!attr.sel) begin
            pos_next = (pos_reg == 3'h0) ? 3'(MSD) : pos_reg - 3'h1; // RULE3
          end
        end else if (standby_reg && kp_press.up) begin
          if (attr.sel) begin
            edit_next = 20'h00000;
            edit_next[3:0] = (edit_reg[3:0] >= attr.sel_cnt - 4'h1) ? 4'h0 : edit_reg[3:0] + 4'h1; // RULE5
          end else begin
            if (dig == DIG_NINE) nd = minus_ok ? DIG_MINUS : 4'h0; // RULE4
            else if (dig == DIG_MINUS) nd = 4'h0;
            else nd = dig + 4'h1; // RULE4
            edit_next[{pos_reg, 2'b00} +: 4] = nd;
          end
        end
      end
    endcase
    if (do_commit) begin
      store_next[pidx_reg] = edit_reg;
      commit_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_LAMP;
      standby_reg <= 1'b0;
      pidx_reg <= INIT_FIRST;
      pos_reg <= 3'(MSD);
      edit_reg <= 20'h00000;
      store_reg <= PARAM_RESET;
      lamp_reg <= 12'h000;
      idle_reg <= 17'h00000;
      commit_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      standby_reg <= standby_next;
      pidx_reg <= pidx_next;
      pos_reg <= pos_next;
      edit_reg <= edit_next;
      store_reg <= store_next;
      lamp_reg <= lamp_next;
      idle_reg <= idle_next;
      commit_reg <= commit_next;
    end
  end

  // held measurement outputs
  always_comb begin
    dc_next = (mode_reg == MODE_MEAS) ? meas_dc : dc_reg; // RULE15
    alm_next = (mode_reg == MODE_MEAS) ? meas_alarm : alm_reg; // RULE15
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dc_reg <= '0;
      alm_reg <= '0;
    end else begin
      dc_reg <= dc_next;
      alm_reg <= alm_next;
    end
  end

  assign mode = mode_reg;
  assign measure_run = mode_reg == MODE_MEAS;
  assign bcd_valid = mode_reg == MODE_MEAS; // RULE15
  assign lamp_test = mode_reg == MODE_LAMP; // RULE18
  assign dc_out = dc_reg;
  assign alarm_out = alm_reg;
  assign param_idx = pidx_reg;
  assign main_digits = standby_reg ? edit_reg : store_cur;
  assign blink_mask = !(standby_reg && blink_reg) ? 5'h00 : attr.sel ? 5'h1F : 5'(5'h01 << pos_reg);
  assign invalid_lamp = standby_reg && edit_bad && blink_reg; // RULE12
  assign secondary_text_display = in_set ? attr.text : 56'h0; // RULE17
  assign commit_pulse = commit_reg;

  a_init_entry: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    (mode_reg == MODE_MEAS && kp_entry.init_up && !p_err) |=> (mode_reg == MODE_INIT && !measure_run))
    else $error("init entry missed");
  a_standby_msd: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    (!standby_reg ##1 (standby_reg && !attr.sel)) |-> pos_reg == 3'(MSD))
    else $error("edit not at leftmost digit");
  a_shift_move: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    (in_set && standby_reg && !attr.sel && kp_press.shift && !busy_ev)
    |=> pos_reg == (($past(pos_reg) == 3'h0) ? 3'(MSD) : $past(pos_reg) - 3'h1))
    else $error("shift did not move digit");
  a_up_increment: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    (in_set && standby_reg && !attr.sel && kp_press.up && !kp_press.shift && !busy_ev && dig < DIG_NINE)
    |=> dig == $past(dig) + 4'h1)
    else $error("digit not incremented");
  a_long_exit: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    (in_set && long_exit && !p_err) |=> (mode_reg == MODE_MEAS && !standby_reg))
    else $error("long hold did not return");
  a_timeout_commit: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    (standby_reg && timeout && !long_exit && !edit_bad)
    |=> (!standby_reg && commit_pulse && mode_reg == $past(mode_reg)))
    else $error("standby timeout no commit");
  a_timeout_return: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    (!standby_reg && timeout && !long_exit && !p_err) |=> mode_reg == MODE_MEAS)
    else $error("idle timeout no return");
  a_abort_keep: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    (in_set && standby_reg && kp_long.extreme && !long_exit && !timeout)
    |=> ((!standby_reg && !commit_pulse && main_digits == $past(store_cur)) ##1 !commit_pulse))
    else $error("abort changed value");
  a_lock_none: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    ((mode_reg == MODE_ALARM || mode_reg == MODE_ADV) && lock_level == NO_EDIT_LEVEL && !standby_reg)
    |=> !standby_reg)
    else $error("edit opened while locked");
  a_minus_refused: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    (in_set && standby_reg && !attr.sel && short_mv && !long_exit && !timeout &&
    (edit_reg[3:0] == DIG_MINUS || edit_reg[7:4] == DIG_MINUS ||
    edit_reg[11:8] == DIG_MINUS || edit_reg[15:12] == DIG_MINUS))
    |=> (standby_reg && !commit_pulse))
    else $error("misplaced minus accepted");
  a_hold_outputs: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    (mode_reg != MODE_MEAS) |=> ($stable(dc_out) && $stable(alarm_out)))
    else $error("outputs not held");
  a_perr_freeze: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    (p_err && mode_reg != MODE_LAMP) |=> mode_reg == $past(mode_reg))
    else $error("mode changed under error");
  a_lamp_time: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
    (mode_reg == MODE_LAMP ##1 mode_reg != MODE_LAMP) |-> $past(lamp_reg) == 12'(LAMP_TEST_MS - 1))
    else $error("lamp test length wrong");
endmodule : fps_front_panel

// ==== verif/fps_operator.sv ====
// operator model: presses and holds front buttons, clean edges, one key at a time
// assumes clk is the system clock and TICK_CYC clocks make one millisecond
`timescale 1ns/10ps
module fps_operator import fps_pkg::*; #(
  parameter int TICK_CYC = 2
) (
  input wire logic clk,
  output fps_keys_s keys_raw
);
  initial keys_raw = '0;

  // hold key k for ms after debounce, release, then let release settle
  task automatic hold_key(input int k, input int ms);
    @(posedge clk);
    keys_raw[k] <= 1'b1;
    repeat ((ms + 25) * TICK_CYC) @(posedge clk);
    keys_raw[k] <= 1'b0;
    repeat (30 * TICK_CYC) @(posedge clk);
  endtask : hold_key
endmodule : fps_operator

// ==== verif/fps_front_panel_tb_top.sv ====
// testbench: drives the setting controller through its operator model and judges ports
// assumes a shortened millisecond tick of two clocks
`timescale 1ns/10ps
module fps_front_panel_tb_top import fps_pkg::*;;
  localparam int TC = 2;
  localparam int K_SHIFT = 0;
  localparam int K_UP = 1;
  localparam int K_DOWN = 2;
  localparam int K_INIT = 3;
  localparam int K_EXT = 4;
  logic clk, sys_rst, p_err, measure_run, bcd_valid, lamp_test, invalid_lamp, commit_pulse, il;
  fps_lock_e lock_level;
  fps_keys_s keys_raw;
  fps_mode_e mode;
  logic [DC_W-1:0] meas_dc, dc_out;
  logic [ALM_W-1:0] meas_alarm, alarm_out;
  logic [2:0] param_idx;
  logic [19:0] main_digits;
  logic [NDIG-1:0] blink_mask, m;
  logic [55:0] sd_text;
  int err_count, check_count, n_commit, c;

  fps_front_panel #(.TICK_CYC(TC)) dut_u (.clk(clk), .sys_rst(sys_rst), .keys_raw(keys_raw),
    .lock_level(lock_level), .p_err(p_err), .meas_dc(meas_dc), .meas_alarm(meas_alarm), .mode(mode),
    .measure_run(measure_run), .bcd_valid(bcd_valid), .lamp_test(lamp_test), .dc_out(dc_out),
    .alarm_out(alarm_out), .param_idx(param_idx), .main_digits(main_digits), .blink_mask(blink_mask),
    .invalid_lamp(invalid_lamp), .secondary_text_display(sd_text), .commit_pulse(commit_pulse));
  fps_operator #(.TICK_CYC(TC)) op_u (.clk(clk), .keys_raw(keys_raw));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) if (commit_pulse === 1'b1) n_commit <= n_commit + 1;

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (exp !== got) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // gather blink and invalid lamp activity over a span of ms
  task automatic watch(input int ms);
    m = '0;
    il = 1'b0;
    repeat (ms * TC) begin
      @(posedge clk);
      m = m | blink_mask;
      il = il | invalid_lamp;
    end
  endtask : watch

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic t_power_up();
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mode", MODE_LAMP, mode);
    chk("lamp_test", 1'b1, lamp_test);
    repeat (3010 * TC) @(posedge clk);
    chk("mode", MODE_MEAS, mode);
    chk("run", 2'b11, {measure_run, bcd_valid});
    chk("dc_out", 16'h1234, dc_out);
  endtask : t_power_up

  task automatic t_init_select();
    op_u.hold_key(K_INIT, 3000);
    meas_dc <= 16'h5678;
    meas_alarm <= 5'h0A;
    chk("mode", MODE_INIT, mode);
    chk("run", 1'b0, measure_run);
    chk("sd", "TCTYPE ", sd_text);
    op_u.hold_key(K_SHIFT, 30);
    watch(1100);
    chk("blink", 5'h1F, m);
    op_u.hold_key(K_UP, 30);
    chk("digits", 20'h00001, main_digits);
    c = n_commit;
    op_u.hold_key(K_DOWN, 30);
    chk("commit", 1, n_commit - c);
    chk("param", 3'h1, param_idx);
    chk("sd", "UNIT   ", sd_text);
    op_u.hold_key(K_INIT, 30);
    chk("param", 3'h0, param_idx);
    chk("digits", 20'h00001, main_digits);
    chk("hold", {16'h1234, 5'h15}, {dc_out, alarm_out});
    op_u.hold_key(K_DOWN, 1000);
    chk("mode", MODE_MEAS, mode);
    chk("dc_out", 16'h5678, dc_out);
  endtask : t_init_select

  task automatic t_err_block();
    p_err <= 1'b1;
    op_u.hold_key(K_INIT, 3000);
    chk("mode", MODE_MEAS, mode);
    p_err <= 1'b0;
  endtask : t_err_block

  task automatic t_alarm_edit();
    op_u.hold_key(K_DOWN, 3000);
    chk("param", 3'h3, param_idx);
    op_u.hold_key(K_SHIFT, 30);
    watch(1100);
    chk("blink", 5'h10, m);
    op_u.hold_key(K_SHIFT, 30);
    watch(1100);
    chk("blink", 5'h08, m);
    repeat (9) op_u.hold_key(K_UP, 30);
    chk("digits", 20'h09000, main_digits);
    op_u.hold_key(K_UP, 30);
    chk("digits", 20'h0A000, main_digits);
    watch(1100);
    chk("invalid", 1'b1, il);
    c = n_commit;
    op_u.hold_key(K_DOWN, 30);
    chk("commit", 0, n_commit - c);
    op_u.hold_key(K_EXT, 1000);
    chk("digits", 20'h00000, main_digits);
    watch(1100);
    chk("blink", 5'h00, m);
    chk("commit", 0, n_commit - c);
  endtask : t_alarm_edit

  task automatic t_lock_idle();
    lock_level <= NO_EDIT_LEVEL;
    op_u.hold_key(K_SHIFT, 30);
    watch(1100);
    chk("blink", 5'h00, m);
    lock_level <= FULL_EDIT_LEVEL;
    op_u.hold_key(K_DOWN, 1000);
    chk("mode", MODE_MEAS, mode);
  endtask : t_lock_idle

  // advanced mode: address range, auto return shortened to 5 s, idle timeouts
  task automatic t_adv_edit();
    op_u.hold_key(K_EXT, 3000);
    chk("param", 3'h4, param_idx);
    chk("sd", "ADDRESS", sd_text);
    repeat (3) op_u.hold_key(K_SHIFT, 30);
    op_u.hold_key(K_UP, 30);
    chk("digits", 20'h00101, main_digits);
    watch(1100);
    chk("invalid", 1'b1, il);
    c = n_commit;
    op_u.hold_key(K_DOWN, 30);
    chk("commit", 0, n_commit - c);
    chk("param", 3'h4, param_idx);
    op_u.hold_key(K_EXT, 1000);
    op_u.hold_key(K_INIT, 30);
    chk("param", 3'h7, param_idx);
    repeat (4) op_u.hold_key(K_SHIFT, 30);
    repeat (9) op_u.hold_key(K_UP, 30);
    chk("digits", 20'h00005, main_digits);
    op_u.hold_key(K_DOWN, 30);
    chk("param", 3'h4, param_idx);
    c = n_commit;
    op_u.hold_key(K_SHIFT, 30);
    repeat (5100 * TC) @(posedge clk);
    watch(600);
    chk("blink", 5'h00, m);
    chk("commit", 1, n_commit - c);
    chk("mode", MODE_ADV, mode);
    repeat (4500 * TC) @(posedge clk);
    chk("mode", MODE_MEAS, mode);
  endtask : t_adv_edit

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected done seen running");
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    p_err = 1'b0;
    lock_level = FULL_EDIT_LEVEL;
    meas_dc = 16'h1234;
    meas_alarm = 5'h15;
    err_count = 0;
    check_count = 0;
    n_commit = 0;
    t_power_up();
    t_init_select();
    t_err_block();
    t_alarm_edit();
    t_lock_idle();
    t_adv_edit();
    summarize();
  end
endmodule : fps_front_panel_tb_top
